// ---- rtl/rivm_top.sv ----
/*
 * Reset and interrupt vector address generator for the 16-Kbyte variant.
 * Presents the fetch address for reset and for the highest priority
 * enabled pending interrupt, with reset entry and table relocation.
 * Assumes requests, enables and the take strobe come from logic on
 * I_SYS_CLK; the fuse and relocate bit are static levels from the core.
 * Limitation: a fuse or relocate change shows three cycles late, so
 * software must settle the relocate bit before enabling any source.
 * Vector offsets are spelled out per source rather than computed, so a
 * reordered source struct shows up as a wrong address, not a silent
 * shift of every vector behind it.
 */
// Summary of operation
// RULE1: reset entry at address zero for pin, power-on, brown-out, watchdog reset
// RULE2: external request zero at 0x0002, one at 0x0004, two words each
// RULE3: pin-change requests zero to two at 0x0006, 0x0008, 0x000A
// RULE4: watchdog time-out interrupt at 0x000C, distinct from watchdog reset
// RULE5: second 8-bit timer: compare A, compare B, overflow at 0x000E-0x0012
// RULE6: 16-bit timer: capture, compare A, compare B, overflow, 0x0014-0x001A
// RULE7: first 8-bit timer: compare A, compare B, overflow at 0x001C-0x0020
// RULE8: serial peripheral transfer complete at 0x0022
// RULE9: serial port receive, buffer empty, transmit complete at 0x0024-0x0028
// RULE10: converter, nvm ready, comparator, two-wire, store ready at 0x002A-0x0032
// RULE11: programmed boot fuse starts execution at boot reset address
// RULE12: relocate bit adds boot flash start to every vector address
// RULE13: reset at zero unless fuse; table at 0x0002 unless relocated
// RULE14: only enabled sources are fetched from
// RULE15: reset entry and vector table placed independently
// RULE16: software sets relocate bit before enabling any interrupt
// RULE17: fuse value zero means programmed, one unprogrammed
// RULE18: lowest vector number dispatched first among pending requests
`timescale 1ns/100ps
`default_nettype none
`include "rivm_regs.svh"

module rivm_top (
    input wire logic I_SYS_CLK, // system clock, 50 MHz
    input wire logic I_RSTN, // synchronous reset, active low
    input wire logic I_BOOT_RESET_SELECT_FUSE, // 0 = programmed
    input wire logic I_VECTOR_RELOCATE_BIT, // relocate table to boot
    input wire rivm_pkg::rivm_src_t I_REQ, // pending requests
    input wire rivm_pkg::rivm_src_t I_EN, // source enables
    input wire logic I_GLOBAL_EN, // global interrupt enable
    input wire logic I_TAKE, // core takes the presented vector
    output logic O_RESET_FETCH, // reset entry presented
    output logic O_IRQ_VALID, // interrupt vector presented
    output logic [`RIVM_SRC_W-1:0] O_IRQ_INDEX, // source, 0 = ext zero
    output logic [`RIVM_ADDR_W-1:0] O_FETCH_ADDR // word fetch address
);

////////////////////////////////////////////////////////////////////////////////

    // synchronised static levels
    logic fuse_s1_ff;
    logic fuse_s2_ff;
    logic reloc_s1_ff;
    logic reloc_s2_ff;

    // reset entry hold count
    logic [1:0] rst_cnt_ff;

    // selection and placement
    rivm_pkg::rivm_pick_t pick;
    rivm_pkg::rivm_req_t gated;
    rivm_pkg::rivm_addr_t reset_addr;
    rivm_pkg::rivm_addr_t table_base;
    rivm_pkg::rivm_addr_t nxt_addr;
    rivm_pkg::rivm_addr_t vec_off;
    logic nxt_valid;
    logic boot_prog;

    // static levels from outside the core domain still get two flops
    always_ff @(posedge I_SYS_CLK) begin
        fuse_s1_ff <= I_BOOT_RESET_SELECT_FUSE;
        fuse_s2_ff <= fuse_s1_ff;
    end

    always_ff @(posedge I_SYS_CLK) begin
        reloc_s1_ff <= I_VECTOR_RELOCATE_BIT;
        reloc_s2_ff <= reloc_s1_ff;
    end

////////////////////////////////////////////////////////////////////////////////
// placement

    // fuse reads low when programmed
    assign boot_prog = (fuse_s2_ff == `RIVM_FUSE_PROGRAMMED); // RULE17

    // RULE13 RULE15: each placement follows its own control only
    // reset entry placement
    always_comb begin
        if (boot_prog) begin
            reset_addr = `RIVM_BOOT_START; // RULE11
        end else begin
            reset_addr = `RIVM_RESET_ADDR; // RULE1
        end
    end

    // table placement
    always_comb begin
        if (reloc_s2_ff) begin
            table_base = `RIVM_BOOT_START + `RIVM_TABLE_BASE; // RULE12
        end else begin
            table_base = `RIVM_TABLE_BASE; // RULE13
        end
    end

////////////////////////////////////////////////////////////////////////////////
// selection

    // disabled sources never reach the picker
    always_comb begin
        if (I_GLOBAL_EN) begin
            gated = rivm_pkg::rivm_req_t'(I_REQ)
                  & rivm_pkg::rivm_req_t'(I_EN); // RULE14
        end else begin
            gated = '0; // RULE14
        end
    end

    // fixed priority, lowest index first
    rivm_prio_pick u_pick (
        .i_req (gated),
        .o_pick (pick)
    ); // RULE18

////////////////////////////////////////////////////////////////////////////////
// vector table

    // vector n sits at base + 2n; one entry per source, two words each,
    // so a reordered request struct shows as a wrong address
    always_comb begin
        vec_off = '0;
        case (pick.index)
            // external requests
            `RIVM_IDX_EXT_ZERO: begin
                vec_off = `RIVM_OFF_EXT_ZERO; // RULE2
            end
            `RIVM_IDX_EXT_ONE: begin
                vec_off = `RIVM_OFF_EXT_ONE; // RULE2
            end

            // pin-change requests
            `RIVM_IDX_PC_ZERO: begin
                vec_off = `RIVM_OFF_PC_ZERO; // RULE3
            end
            `RIVM_IDX_PC_ONE: begin
                vec_off = `RIVM_OFF_PC_ONE; // RULE3
            end
            `RIVM_IDX_PC_TWO: begin
                vec_off = `RIVM_OFF_PC_TWO; // RULE3
            end

            // watchdog time-out, not the watchdog reset
            `RIVM_IDX_WDOG: begin
                vec_off = `RIVM_OFF_WDOG; // RULE4
            end

            // second 8-bit timer
            `RIVM_IDX_T2_CMPA: begin
                vec_off = `RIVM_OFF_T2_CMPA; // RULE5
            end
            `RIVM_IDX_T2_CMPB: begin
                vec_off = `RIVM_OFF_T2_CMPB; // RULE5
            end
            `RIVM_IDX_T2_OVF: begin
                vec_off = `RIVM_OFF_T2_OVF; // RULE5
            end

            // 16-bit timer
            `RIVM_IDX_T1_CAPT: begin
                vec_off = `RIVM_OFF_T1_CAPT; // RULE6
            end
            `RIVM_IDX_T1_CMPA: begin
                vec_off = `RIVM_OFF_T1_CMPA; // RULE6
            end
            `RIVM_IDX_T1_CMPB: begin
                vec_off = `RIVM_OFF_T1_CMPB; // RULE6
            end
            `RIVM_IDX_T1_OVF: begin
                vec_off = `RIVM_OFF_T1_OVF; // RULE6
            end

            // first 8-bit timer
            `RIVM_IDX_T0_CMPA: begin
                vec_off = `RIVM_OFF_T0_CMPA; // RULE7
            end
            `RIVM_IDX_T0_CMPB: begin
                vec_off = `RIVM_OFF_T0_CMPB; // RULE7
            end
            `RIVM_IDX_T0_OVF: begin
                vec_off = `RIVM_OFF_T0_OVF; // RULE7
            end

            // serial peripheral transfer
            `RIVM_IDX_SPI_DONE: begin
                vec_off = `RIVM_OFF_SPI_DONE; // RULE8
            end

            // serial port
            `RIVM_IDX_RX_DONE: begin
                vec_off = `RIVM_OFF_RX_DONE; // RULE9
            end
            `RIVM_IDX_TX_EMPTY: begin
                vec_off = `RIVM_OFF_TX_EMPTY; // RULE9
            end
            `RIVM_IDX_TX_DONE: begin
                vec_off = `RIVM_OFF_TX_DONE; // RULE9
            end

            // remaining sources in vector order
            `RIVM_IDX_CONV_DONE: begin
                vec_off = `RIVM_OFF_CONV_DONE; // RULE10
            end
            `RIVM_IDX_NVM_RDY: begin
                vec_off = `RIVM_OFF_NVM_RDY; // RULE10
            end
            `RIVM_IDX_CMP_EVT: begin
                vec_off = `RIVM_OFF_CMP_EVT; // RULE10
            end
            `RIVM_IDX_TWO_WIRE: begin
                vec_off = `RIVM_OFF_TWO_WIRE; // RULE10
            end
            `RIVM_IDX_STORE_RDY: begin
                vec_off = `RIVM_OFF_STORE_RDY; // RULE10
            end
            default: begin
                vec_off = '0;
            end
        endcase
    end

    // a take clears valid for one cycle only; a request still held
    // after that is presented again
    always_comb begin
        nxt_valid = pick.valid && !I_TAKE;
    end

    always_comb begin
        nxt_addr = table_base + vec_off; // RULE12
    end

////////////////////////////////////////////////////////////////////////////////
// outputs

    // reset entry held a few cycles so the fuse synchroniser settles first
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            rst_cnt_ff <= `RIVM_SYNC_RST;
        end else if (rst_cnt_ff != `RIVM_RST_DONE) begin
            rst_cnt_ff <= rst_cnt_ff + 2'h1;
        end
    end

    // every output comes straight from a flop
    // reset entry wins over any request while the count runs
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            O_RESET_FETCH <= 1'b1; // RULE1
        end else if (rst_cnt_ff != `RIVM_RST_DONE) begin
            O_RESET_FETCH <= 1'b1; // RULE1
        end else begin
            O_RESET_FETCH <= 1'b0;
        end
    end

    // no vector is presented during reset entry
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            O_IRQ_VALID <= 1'b0;
        end else if (rst_cnt_ff != `RIVM_RST_DONE) begin
            O_IRQ_VALID <= 1'b0;
        end else begin
            O_IRQ_VALID <= nxt_valid; // RULE14
        end
    end

    // index of the winner, cleared during reset entry
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            O_IRQ_INDEX <= '0;
        end else if (rst_cnt_ff != `RIVM_RST_DONE) begin
            O_IRQ_INDEX <= '0;
        end else begin
            O_IRQ_INDEX <= pick.index; // RULE18
        end
    end

    // idle address falls back to the reset entry
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            O_FETCH_ADDR <= `RIVM_RESET_ADDR;
        end else if (rst_cnt_ff != `RIVM_RST_DONE) begin
            O_FETCH_ADDR <= reset_addr; // RULE1 RULE11
        end else begin
            O_FETCH_ADDR <= nxt_valid ? nxt_addr : reset_addr; // RULE12
        end
    end

endmodule
`default_nettype wire

// ---- rtl/rivm_regs.svh ----
/*
 * Constants of the reset and interrupt vector map: vector addresses,
 * widths, fuse polarity and the boot flash start address.
 * Assumes inclusion from the package and the design modules by bare name.
 */
`ifndef RIVM_REGS_SVH
`define RIVM_REGS_SVH

`define RIVM_ADDR_W 13
`define RIVM_NSRC 25
`define RIVM_SRC_W 5
`define RIVM_RESET_ADDR 13'h0000
`define RIVM_TABLE_BASE 13'h0002
`define RIVM_VEC_STEP 13'h0002
`define RIVM_BOOT_START 13'h1c00
`define RIVM_FUSE_PROGRAMMED 1'b0
`define RIVM_SYNC_RST 2'h0
`define RIVM_RST_DONE 2'h3

`define RIVM_IDX_EXT_ZERO 5'h00
`define RIVM_IDX_EXT_ONE 5'h01
`define RIVM_IDX_PC_ZERO 5'h02
`define RIVM_IDX_PC_ONE 5'h03
`define RIVM_IDX_PC_TWO 5'h04
`define RIVM_IDX_WDOG 5'h05
`define RIVM_IDX_T2_CMPA 5'h06
`define RIVM_IDX_T2_CMPB 5'h07
`define RIVM_IDX_T2_OVF 5'h08
`define RIVM_IDX_T1_CAPT 5'h09
`define RIVM_IDX_T1_CMPA 5'h0a
`define RIVM_IDX_T1_CMPB 5'h0b
`define RIVM_IDX_T1_OVF 5'h0c
`define RIVM_IDX_T0_CMPA 5'h0d
`define RIVM_IDX_T0_CMPB 5'h0e
`define RIVM_IDX_T0_OVF 5'h0f
`define RIVM_IDX_SPI_DONE 5'h10
`define RIVM_IDX_RX_DONE 5'h11
`define RIVM_IDX_TX_EMPTY 5'h12
`define RIVM_IDX_TX_DONE 5'h13
`define RIVM_IDX_CONV_DONE 5'h14
`define RIVM_IDX_NVM_RDY 5'h15
`define RIVM_IDX_CMP_EVT 5'h16
`define RIVM_IDX_TWO_WIRE 5'h17
`define RIVM_IDX_STORE_RDY 5'h18

`define RIVM_OFF_EXT_ZERO 13'h0000
`define RIVM_OFF_EXT_ONE 13'h0002
`define RIVM_OFF_PC_ZERO 13'h0004
`define RIVM_OFF_PC_ONE 13'h0006
`define RIVM_OFF_PC_TWO 13'h0008
`define RIVM_OFF_WDOG 13'h000a
`define RIVM_OFF_T2_CMPA 13'h000c
`define RIVM_OFF_T2_CMPB 13'h000e
`define RIVM_OFF_T2_OVF 13'h0010
`define RIVM_OFF_T1_CAPT 13'h0012
`define RIVM_OFF_T1_CMPA 13'h0014
`define RIVM_OFF_T1_CMPB 13'h0016
`define RIVM_OFF_T1_OVF 13'h0018
`define RIVM_OFF_T0_CMPA 13'h001a
`define RIVM_OFF_T0_CMPB 13'h001c
`define RIVM_OFF_T0_OVF 13'h001e
`define RIVM_OFF_SPI_DONE 13'h0020
`define RIVM_OFF_RX_DONE 13'h0022
`define RIVM_OFF_TX_EMPTY 13'h0024
`define RIVM_OFF_TX_DONE 13'h0026
`define RIVM_OFF_CONV_DONE 13'h0028
`define RIVM_OFF_NVM_RDY 13'h002a
`define RIVM_OFF_CMP_EVT 13'h002c
`define RIVM_OFF_TWO_WIRE 13'h002e
`define RIVM_OFF_STORE_RDY 13'h0030

`endif

// ---- rtl/rivm_pkg.sv ----
/*
 * Types of the reset and interrupt vector map.
 * Assumes rivm_regs.svh on the include path.
 */
`include "rivm_regs.svh"

package rivm_pkg;

    typedef logic [`RIVM_ADDR_W-1:0] rivm_addr_t;
    typedef logic [`RIVM_NSRC-1:0] rivm_req_t;

    // one bit per source, lowest vector number in bit 0
    typedef struct packed {
        logic program_store_ready;
        logic two_wire;
        logic comparator;
        logic data_nvm_ready;
        logic converter;
        logic tx_complete;
        logic tx_buffer_empty;
        logic rx_complete;
        logic spi_complete;
        logic t0_ovf;
        logic t0_cmpb;
        logic t0_cmpa;
        logic t1_ovf;
        logic t1_cmpb;
        logic t1_cmpa;
        logic t1_capt;
        logic t2_ovf;
        logic t2_cmpb;
        logic t2_cmpa;
        logic watchdog_timeout_request;
        logic pin_change_request_two;
        logic pin_change_request_one;
        logic pin_change_request_zero;
        logic ext_request_one;
        logic ext_request_zero;
    } rivm_src_t;

    typedef struct packed {
        logic valid;
        logic [`RIVM_SRC_W-1:0] index;
    } rivm_pick_t;

endpackage

// ---- rtl/rivm_prio_pick.sv ----
/*
 * Fixed priority picker: lowest set bit wins.
 * Assumes requests already gated by their enables, same clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rivm_regs.svh"

module rivm_prio_pick (
    input wire logic [`RIVM_NSRC-1:0] i_req, // gated requests
    output var rivm_pkg::rivm_pick_t o_pick // winner, combinational
);

    always_comb begin
        o_pick = '0;
        for (int i = `RIVM_NSRC - 1; i >= 0; i--) begin
            if (i_req[i]) begin
                o_pick.valid = 1'b1;
                o_pick.index = `RIVM_SRC_W'(i);
            end
        end
    end

endmodule
`default_nettype wire

// ---- verification/rivm_core_model.sv ----
/* Core fetch model: takes a presented vector when told to.
 * Assumes the bench clock and the design's valid output. */
`timescale 1ns/100ps
`default_nettype none
module rivm_core_model (
    input wire logic i_clk, // system clock
    input wire logic i_accept, // take presented vectors
    input wire logic i_valid, // vector presented
    output logic o_take // take strobe
);
    initial o_take = 1'b0;
    // single pulse: a held request is not taken twice in a row
    always @(posedge i_clk) begin
        o_take <= i_accept && i_valid && !o_take;
    end
endmodule
`default_nettype wire

// ---- verification/rivm_checker.sv ----
/* Port checker for rivm_top, bound below.
 * Assumes fuse and relocate bit change only while reset is held. */
`timescale 1ns/100ps
`default_nettype none
module rivm_checker (
    input wire logic I_SYS_CLK, // clock
    input wire logic I_RSTN, // reset
    input wire logic I_BOOT_RESET_SELECT_FUSE, // fuse
    input wire logic I_VECTOR_RELOCATE_BIT, // relocate
    input wire rivm_pkg::rivm_src_t I_REQ, // requests
    input wire rivm_pkg::rivm_src_t I_EN, // enables
    input wire logic I_GLOBAL_EN, // global enable
    input wire logic I_TAKE, // take
    input wire logic O_RESET_FETCH, // reset fetch
    input wire logic O_IRQ_VALID, // valid
    input wire logic [4:0] O_IRQ_INDEX, // index
    input wire logic [12:0] O_FETCH_ADDR // address
);
    wire logic [24:0] g = I_REQ & I_EN;
    wire logic [12:0] ra = I_BOOT_RESET_SELECT_FUSE ? 13'h0000 : 13'h1c00;
    wire logic [12:0] va = (I_VECTOR_RELOCATE_BIT ? 13'h1c02 : 13'h0002)
        + {7'h00, O_IRQ_INDEX, 1'b0};
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RSTN);
    AST_VEC_ADDR: assert property (O_IRQ_VALID |-> O_FETCH_ADDR == va)
        else $error("vector address wrong");
    AST_RST_ADDR: assert property (O_RESET_FETCH && $past(I_RSTN)
        |-> O_FETCH_ADDR == ra) else $error("reset address wrong");
    AST_IDLE_ADDR: assert property (!O_IRQ_VALID && !O_RESET_FETCH
        |-> O_FETCH_ADDR == ra) else $error("idle address wrong");
    AST_RST_HOLD: assert property ($rose(I_RSTN)
        |-> O_RESET_FETCH[*4] ##1 !O_RESET_FETCH) else $error("reset span");
    AST_NO_IRQ_RST: assert property (O_RESET_FETCH |-> !O_IRQ_VALID)
        else $error("vector during reset entry");
    AST_CAUSE: assert property (O_IRQ_VALID
        |-> $past(I_GLOBAL_EN) && $past(g) != 25'h0) else $error("no cause");
    AST_LOWEST: assert property (O_IRQ_VALID
        |-> (($past(g) >> O_IRQ_INDEX) & 25'h1) == 25'h1
        && ($past(g) & ((25'h1 << O_IRQ_INDEX) - 25'h1)) == 25'h0)
        else $error("not lowest");
    AST_TAKE: assert property (I_TAKE |=> !O_IRQ_VALID)
        else $error("valid after take");
endmodule
bind rivm_top rivm_checker u_chk (.I_SYS_CLK, .I_RSTN,
    .I_BOOT_RESET_SELECT_FUSE, .I_VECTOR_RELOCATE_BIT, .I_REQ, .I_EN,
    .I_GLOBAL_EN, .I_TAKE, .O_RESET_FETCH, .O_IRQ_VALID, .O_IRQ_INDEX,
    .O_FETCH_ADDR);
`default_nettype wire

// ---- verification/rivm_top_tb.sv ----
/* Bench for rivm_top with a core model taking vectors.
 * Assumes design, checker and core model compiled first. */
`timescale 1ns/100ps
`default_nettype none
module rivm_top_tb;
    logic clk = 1'b0, rstn = 1'b0, fuse = 1'b1, reloc = 1'b0;
    logic gen = 1'b1, acc = 1'b0, take, rf, vld;
    rivm_pkg::rivm_src_t req = '0, en = '0;
    logic [4:0] idx;
    logic [12:0] addr;
    int n_errors = 0, num_checks = 0;
    always #10 clk = ~clk;
    rivm_top DUT (.I_SYS_CLK(clk), .I_RSTN(rstn),
        .I_BOOT_RESET_SELECT_FUSE(fuse), .I_VECTOR_RELOCATE_BIT(reloc),
        .I_REQ(req), .I_EN(en), .I_GLOBAL_EN(gen), .I_TAKE(take),
        .O_RESET_FETCH(rf), .O_IRQ_VALID(vld), .O_IRQ_INDEX(idx),
        .O_FETCH_ADDR(addr));
    rivm_core_model u_core (.i_clk(clk), .i_accept(acc), .i_valid(vld),
        .o_take(take));
    task automatic chk(input string w, input logic [12:0] s, e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", w, e, s);
        end
    endtask
    task automatic nxt;
        @(posedge clk);
        #1;
    endtask
    task automatic do_reset(input logic f, r, input int n);
        @(posedge clk);
        rstn <= 1'b0;
        fuse <= f;
        reloc <= r;
        repeat (n) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) nxt;
        chk("entry", 13'(rf), 13'h1);
        chk("raddr", addr, f ? 13'h0000 : 13'h1c00);
        nxt;
        chk("entry_end", 13'(rf), 13'h0);
    endtask
    task automatic vec_scan;
        for (int i = 0; i < 25; i++) begin
            @(posedge clk);
            req <= 25'h1 << i;
            en <= '1;
            nxt;
            chk("valid", 13'(vld), 13'h1);
            chk("idx", 13'(idx), 13'(i));
            chk("addr", addr, (reloc ? 13'h1c02 : 13'h0002) + 13'(2 * i));
        end
    endtask
    task automatic prio_gate;
        for (int i = 0; i < 25; i++) begin
            @(posedge clk);
            req <= '1;
            en <= 25'h1ffffff << i;
            nxt;
            chk("prio", 13'(idx), 13'(i));
        end
        @(posedge clk);
        en <= '0;
        nxt;
        chk("off_src", 13'(vld), 13'h0);
        @(posedge clk);
        en <= '1;
        gen <= 1'b0;
        nxt;
        chk("off_all", 13'(vld), 13'h0);
        @(posedge clk);
        gen <= 1'b1;
    endtask
    task automatic take_seq;
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        req <= 25'h2;
        acc <= 1'b1;
        repeat (3) nxt;
        chk("taken", 13'(vld), 13'h0);
        chk("taddr", addr, fuse ? 13'h0000 : 13'h1c00);
        nxt;
        chk("again", addr, reloc ? 13'h1c04 : 13'h0004);
        @(posedge clk);
        acc <= 1'b0;
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        do_reset(1'b1, 1'b0, 2);
        vec_scan;
        prio_gate;
        take_seq;
        do_reset(1'b0, 1'b0, 4);
        vec_scan;
        do_reset(1'b1, 1'b1, 4);
        vec_scan;
        do_reset(1'b0, 1'b1, 4);
        take_seq;
        end_of_test;
    end
    initial begin
        #100000;
        n_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
